//--- include/wiper_port_pkg.sv
// Shared constants and carrier types for the six-wiper serial shift port
package wiper_port_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int WIPER_COUNT = 6;
    localparam int FIELD_BITS = 8;
    localparam int POS_BITS = 6;
    localparam int SHIFT_BITS = WIPER_COUNT * FIELD_BITS;
    localparam int HOLD_LSB = 6;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 1;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] HOLD_CODE = 2'h3;
    localparam logic [POS_BITS-1:0] WIPER_RESET = 6'h00;
    localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 48'h0000_0000_0000;
    localparam logic [2:0] LINK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic port_enable;
        logic serial_clock;
        logic serial_data;
    } link_in_type;

    typedef struct packed {
        logic [1:0] hold;
        logic [POS_BITS-1:0] position;
    } wiper_field_type;

    typedef logic [WIPER_COUNT-1:0][POS_BITS-1:0] wiper_set_type;

endpackage

//--- hdl/six_wiper_serial_shift_port.sv
// Serial shift port, bit FIFO and wiper registers of a six-wiper pot
`timescale 1ns/1ps

// How it works
// R01 - After reset every wiper sits at position zero, the low end.
// R02 - The serial port acts only while serial_port_enable is high.
// R03 - Host opens every wiper-changing transaction with enable rising.
// R04 - Input bits enter a 48-bit shift register one at a time, LSB first.
// R05 - While enabled, each serial clock rising edge samples serial_data_in.
// R06 - Host sends potentiometer one's field first, then two through six.
// R07 - Each field is 8 bits; bits 0 to 5 hold the wiper position.
// R08 - Field bits 7:6 equal 11 keep the wiper; otherwise bits 5:0 apply.
// R09 - Position 63 is the high end, 0 the low end, one step per code.
// R10 - Host shifts all 48 bits in every read or write transaction.
// R11 - First bit on cascade_data_out is potentiometer one's field LSB.
// R12 - cascade_data_out is driven at all times, enabled or not.
// R13 - With enable low, data and clock are ignored; register holds.
// R14 - Chained devices need exactly 48 bits per device per transaction.
// R15 - Last register bit drives cascade output; new bit enters position one.
// R16 - Enable falling ends the transfer and applies fields to the wipers.
// R17 - Looping cascade out to data in for 48 bits leaves wipers unchanged.
// R18 - After reset the shift register holds all zeros, matching wipers.

// ----------------------------------------------------------------------
// Small FIFO with valid/ready on both sides
// ----------------------------------------------------------------------
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] fill;
    logic push;
    logic pop;

    assign fill = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Depth is a power of two, so pointers wrap naturally
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Top: link sampling, shift register, wiper apply
// ----------------------------------------------------------------------
module six_wiper_serial_shift_port (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic serial_port_enable,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic cascade_data_out,
    output wiper_port_pkg::wiper_set_type wiper_position,
    output logic transfer_active,
    output logic bit_overrun
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wiper_port_pkg::link_in_type link_raw;
    wiper_port_pkg::link_in_type link_meta_reg;
    wiper_port_pkg::link_in_type link_sync_reg;
    wiper_port_pkg::link_in_type link_prev_reg;

    assign link_raw.port_enable = serial_port_enable;
    assign link_raw.serial_clock = serial_clock;
    assign link_raw.serial_data = serial_data_in;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link_meta_reg <= wiper_port_pkg::LINK_RESET;
            link_sync_reg <= wiper_port_pkg::LINK_RESET;
        end else begin
            link_meta_reg <= link_raw;
            link_sync_reg <= link_meta_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link_prev_reg <= wiper_port_pkg::LINK_RESET;
        end else begin
            link_prev_reg <= link_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic port_on;
    logic clock_rise;
    logic enable_fall;

    assign port_on = link_sync_reg.port_enable; // [R02]
    // Clock edges count only while the port is on; stray edges are dropped
    assign clock_rise = port_on && link_sync_reg.serial_clock
        && !link_prev_reg.serial_clock; // [R05] [R13]
    assign enable_fall = link_prev_reg.port_enable
        && !link_sync_reg.port_enable; // [R16]

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            transfer_active <= 1'b0;
        end else begin
            transfer_active <= port_on; // [R02]
        end
    end

    // ------------------------------------------------------------------
    // Bit FIFO between sampling and the shift register
    // ------------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [wiper_port_pkg::FIFO_WIDTH-1:0] fifo_out_data;
    logic apply_pending_reg;
    logic apply_now;

    // Apply waits for every bit of the closing frame to be shifted in
    assign apply_now = apply_pending_reg && !fifo_out_valid;
    assign fifo_out_ready = !apply_now;

    bit_fifo #(
        .WIDTH(wiper_port_pkg::FIFO_WIDTH),
        .DEPTH(wiper_port_pkg::FIFO_DEPTH)
    ) sample_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(clock_rise),
        .in_ready(fifo_in_ready),
        .in_data(link_sync_reg.serial_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Cannot happen at the rated link rate; flagged rather than hidden
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bit_overrun <= 1'b0;
        end else if (clock_rise && !fifo_in_ready) begin
            bit_overrun <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    logic [wiper_port_pkg::SHIFT_BITS-1:0] shift_reg;
    logic [wiper_port_pkg::SHIFT_BITS-1:0] shift_next;
    logic shift_step;

    assign shift_step = fifo_out_valid && fifo_out_ready;

    always_comb begin
        shift_next = shift_reg;
        if (shift_step) begin
            // New bit into position one, top bit toward the output
            shift_next = {shift_reg[wiper_port_pkg::SHIFT_BITS-2:0],
                fifo_out_data[0]}; // [R04] [R15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shift_reg <= wiper_port_pkg::SHIFT_RESET; // [R18]
        end else begin
            shift_reg <= shift_next; // [R13]
        end
    end

    // Top bit holds pot one LSB of the previous frame at frame start
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cascade_data_out <= 1'b0;
        end else begin
            cascade_data_out <= shift_next[wiper_port_pkg::SHIFT_BITS-1];
        end // [R11] [R12] [R15]
    end

    // ------------------------------------------------------------------
    // Apply sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            apply_pending_reg <= 1'b0;
        end else if (enable_fall) begin
            apply_pending_reg <= 1'b1; // [R16]
        end else if (apply_now) begin
            apply_pending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Wiper registers, one per channel
    // ------------------------------------------------------------------
    // Pot one arrived first, so it sits at the top byte, LSB highest
    genvar ch;
    genvar b;
    generate
        for (ch = 0; ch < wiper_port_pkg::WIPER_COUNT; ch++) begin : g_wiper
            logic [wiper_port_pkg::FIELD_BITS-1:0] field_bits;
            wiper_port_pkg::wiper_field_type field;

            for (b = 0; b < wiper_port_pkg::FIELD_BITS; b++) begin : g_bit
                assign field_bits[b] = shift_reg[wiper_port_pkg::SHIFT_BITS-1
                    - ch*wiper_port_pkg::FIELD_BITS - b]; // [R06] [R07]
            end
            assign field = field_bits;

            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    wiper_position[ch] <= wiper_port_pkg::WIPER_RESET; // [R01]
                end else if (apply_now
                    && field.hold != wiper_port_pkg::HOLD_CODE) begin // [R08]
                    // Code maps straight to tap count above low end
                    wiper_position[ch] <= field.position; // [R09] [R17]
                end
            end
        end
    endgenerate

endmodule

//--- tb/wiper_port_sva.sv
// Port checks for the six-wiper serial shift port
`timescale 1ns/1ps
module wiper_port_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic serial_port_enable,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic cascade_data_out,
    input wire wiper_port_pkg::wiper_set_type wiper_position,
    input wire logic transfer_active,
    input wire logic bit_overrun
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic sck_reg;
    logic [3:0] rise_cnt_reg;
    logic [3:0] idle_cnt_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge sys_clk) begin
        sck_reg <= serial_clock;
    end
    // Cycles since a serial clock rise was seen on the pin
    always_ff @(posedge sys_clk) begin
        if (!rst_b) rise_cnt_reg <= 4'hf;
        else if (serial_clock && !sck_reg) rise_cnt_reg <= 4'h0;
        else if (rise_cnt_reg != 4'hf) rise_cnt_reg <= rise_cnt_reg + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b || transfer_active) idle_cnt_reg <= 4'h0;
        else if (idle_cnt_reg != 4'hf) idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_state: assert property (disable iff (1'b0)
        !rst_b |=> wiper_position == '0 && !cascade_data_out
        && !transfer_active && !bit_overrun) else $error("bad reset state");
    a_enable_rise: assert property (
        $rose(serial_port_enable) |-> ##[1:4] transfer_active)
        else $error("enable rise not followed");
    a_enable_fall: assert property (
        $fell(serial_port_enable) |-> ##[1:4] !transfer_active)
        else $error("enable fall not followed");
    a_active_needs_en: assert property (
        $rose(transfer_active) |-> $past(serial_port_enable))
        else $error("active without enable");
    a_idle_cascade_still: assert property (
        !transfer_active [*8] |-> $stable(cascade_data_out))
        else $error("cascade moved while idle");
    a_wiper_apply_time: assert property (
        $changed(wiper_position) |-> !transfer_active && idle_cnt_reg < 4'h8)
        else $error("wipers changed outside apply window");
    a_wiper_hold_active: assert property (
        transfer_active |-> $stable(wiper_position))
        else $error("wipers changed mid-frame");
    a_cascade_after_rise: assert property (
        $changed(cascade_data_out) |-> rise_cnt_reg inside {[4'h1:4'h7]})
        else $error("cascade moved without clock rise");
    a_no_overrun: assert property (
        !bit_overrun) else $error("bit overrun at slow link");
    c_frame_end: cover property ($fell(transfer_active));
    c_wiper_move: cover property ($changed(wiper_position));
    c_shift: cover property ($changed(cascade_data_out) && transfer_active);
endmodule

//--- tb/wiper_host_model.sv
// Behavioural host that clocks frames through the wiper port
`timescale 1ns/1ps
module wiper_host_model (
    output logic serial_port_enable,
    output logic serial_clock,
    output logic serial_data_in,
    input wire logic cascade_data_out
);
    logic [47:0] rd_bits;
    initial begin
        serial_port_enable = 1'b0;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
        rd_bits = '0;
    end
    // Released data line wanders so a stale bit is never taken as data
    always #130 if (!serial_port_enable) serial_data_in = ~serial_data_in;
    // Data set one system cycle before the rise; cascade read just before
    task automatic frame(input logic [47:0] bits, input int n, input bit loop);
        rd_bits = '0;
        #37;
        serial_port_enable = 1'b1;
        for (int i = 0; i < n; i++) begin
            #300;
            rd_bits[i] = cascade_data_out;
            serial_data_in = loop ? cascade_data_out : bits[i];
            #100;
            serial_clock = 1'b1;
            #400;
            serial_clock = 1'b0;
        end
        #800;
        serial_port_enable = 1'b0;
        #800;
    endtask
    // Clock pulses with the port disabled, which the device must ignore
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            #200;
            serial_clock = 1'b1;
            #200;
            serial_clock = 1'b0;
        end
    endtask
endmodule

//--- tb/six_wiper_serial_shift_port_tb.sv
// Self-checking bench for the six-wiper serial shift port
`timescale 1ns/1ps
module six_wiper_serial_shift_port_tb;
    typedef struct packed {
        wiper_port_pkg::wiper_set_type w;
        logic [47:0] rd;
    } note_type;
    localparam int TIMEOUT = 20000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic serial_port_enable, serial_clock, serial_data_in;
    logic cascade_data_out, transfer_active, bit_overrun;
    wiper_port_pkg::wiper_set_type wiper_position;
    wiper_port_pkg::wiper_set_type w_model = '0;
    logic [47:0] sr_model = '0;
    note_type notes[$];
    note_type cur;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    always #50 sys_clk = ~sys_clk;
    six_wiper_serial_shift_port uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .serial_port_enable(serial_port_enable), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .cascade_data_out(cascade_data_out),
        .wiper_position(wiper_position), .transfer_active(transfer_active),
        .bit_overrun(bit_overrun));
    wiper_host_model host (.serial_port_enable(serial_port_enable),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .cascade_data_out(cascade_data_out));
    // ------------------------------------------------------------------
    // Compare, verdict, timeout
    // ------------------------------------------------------------------
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Driver with reference model, and result monitor
    // ------------------------------------------------------------------
    task automatic send(input logic [47:0] bits, input int n, input bit loop);
        note_type nt;
        logic b;
        nt.rd = '0;
        for (int i = 0; i < n; i++) begin
            nt.rd[i] = sr_model[47];
            b = loop ? sr_model[47] : bits[i];
            sr_model = {sr_model[46:0], b};
        end
        for (int k = 0; k < 6; k++) begin
            if (!(sr_model[41-8*k] && sr_model[40-8*k])) begin
                for (int j = 0; j < 6; j++) begin
                    w_model[k][j] = sr_model[47-8*k-j];
                end
            end
        end
        nt.w = w_model;
        notes.push_back(nt);
        host.frame(bits, n, loop);
    endtask
    always @(negedge transfer_active) begin
        if (rst_b && notes.size() > 0) begin
            cur = notes.pop_front();
            // Must look before the next frame clears the host's read bits
            repeat (4) @(posedge sys_clk);
            #1;
            cmp(48'(wiper_position), 48'(cur.w));
            cmp(host.rd_bits, cur.rd);
        end
    end
    initial begin
        void'($urandom(97));
        repeat (10) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp(48'(wiper_position), 48'h0);
        cmp({47'h0, cascade_data_out}, 48'h0);
        // Ends of range, all four top-bit codes, one kept wiper
        send(48'h2aea954f003f, 48, 1'b0);
        for (int i = 0; i < 3; i++) begin
            send({16'($urandom), 32'($urandom)}, 48, 1'b0);
        end
        send(48'h0, 48, 1'b1);
        host.noise(6);
        send(48'h0, 0, 1'b0);
        send({16'($urandom), 32'($urandom)}, 20, 1'b0);
        send(48'h0, 48, 1'b1);
        repeat (20) @(posedge sys_clk);
        #1;
        cmp({47'h0, cascade_data_out}, {47'h0, sr_model[47]});
        print_verdict();
    end
endmodule

bind six_wiper_serial_shift_port wiper_port_sva chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .serial_port_enable(serial_port_enable),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .cascade_data_out(cascade_data_out), .wiper_position(wiper_position),
    .transfer_active(transfer_active), .bit_overrun(bit_overrun));
